// ---- rtl/bpp_pkg.sv ----
package bpp_pkg;

  // ----------------------------------------------------------------------
  // Bank geometry
  // ----------------------------------------------------------------------
  localparam int BPP_NPORT = 9;
  localparam int BPP_PW = 16;
  localparam int BPP_NLINE = BPP_NPORT * BPP_PW;
  localparam int BPP_NBYTE = BPP_NPORT * 2;
  localparam int BPP_AW = 12;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int BPP_PORT_SHIFT = 4;
  localparam logic [3:0] BPP_OFF_DATA = 4'h0;
  localparam logic [3:0] BPP_OFF_DIR = 4'h4;
  localparam logic [3:0] BPP_OFF_OD = 4'h8;
  localparam logic [3:0] BPP_OFF_TGL = 4'hC;
  localparam logic [11:0] BPP_OFF_THR = 12'h100;
  localparam logic [11:0] BPP_OFF_XTHR = 12'h104;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [15:0] BPP_RST_LATCH = 16'h0000;
  localparam logic [15:0] BPP_RST_DIR = 16'h0000;
  localparam logic [15:0] BPP_RST_OD = 16'h0000;
  localparam logic [10:0] BPP_RST_THR = 11'h000;
  localparam logic [2:0] BPP_RST_XTHR = 3'h0;
  localparam int BPP_THR_W = 11;
  localparam int BPP_XTHR_W = 3;

  // ----------------------------------------------------------------------
  // Bus handshake states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BPP_ST_IDLE = 2'b01,
    BPP_ST_RESP = 2'b10
  } bpp_state_t;

  // ----------------------------------------------------------------------
  // Per-port line maps
  // ----------------------------------------------------------------------
  // Lines that exist: byte ports use the low half, port 3 lacks line 14.
  function automatic logic [15:0] bpp_impl_mask(input int p);
    case (p)
      3: bpp_impl_mask = 16'hBFFF;
      4, 6, 7, 8: bpp_impl_mask = 16'h00FF;
      default: bpp_impl_mask = 16'hFFFF;
    endcase
  endfunction

  // Lines with an output driver; port 5 is input only.
  function automatic logic [15:0] bpp_drv_mask(input int p);
    bpp_drv_mask = (p == 5) ? 16'h0000 : bpp_impl_mask(p);
  endfunction

  // Lines whose driver may be switched to open drain.
  function automatic logic [15:0] bpp_od_mask(input int p);
    bpp_od_mask = (p >= 2 && p != 5) ? bpp_impl_mask(p) : 16'h0000;
  endfunction

  // Index of the threshold bit in {ext, main} for byte b of port p, or -1.
  function automatic int bpp_thr_bit(input int p, input int b);
    case (p)
      0, 1, 2, 3: bpp_thr_bit = p * 2 + b;
      4: bpp_thr_bit = (b == 0) ? 8 : -1;
      5: bpp_thr_bit = 9 + b;
      default: bpp_thr_bit = (b == 0) ? 11 + (p - 6) : -1;
    endcase
  endfunction

endpackage

// ---- rtl/bpp_port_bank.sv ----
`timescale 1ns/1ps

// Contract
// - Sample every pin each cycle, any direction.
// - Input pin: write latch, read pin.
// - Input pin: read-modify-write uses pin value.
// - Direction one enables driver with latch.
// - Output pin: reads and modifies the latch.
// - Per-bit open drain on capable ports.
// - Threshold select per byte, two for wide.
// - Direction works independent of threshold.
// - Port 3 has no line 14.
// - Port 5 input only, no drivers.
// - Alternate output needs output direction.
// - Pin drives latch AND alternate data, PWM lines alternate data alone.
// - Direction is input after reset.
// - Output pin loops latch to alternate input.
// - Bus lines switch direction in hardware.
// - Reset-critical lines set direction automatically.
// - One alternate function per line.
// - Ports 0 and 1 byte addressable.
// - Unused alternate lines stay plain I/O.

module bpp_port_bank #(
  parameter logic [143:0] RESET_AUTO_DIR = 144'h0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bpp_pkg::BPP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads, port p on lines [p*16 +: 16]
  input wire logic [bpp_pkg::BPP_NLINE-1:0] pinIn,
  output logic [bpp_pkg::BPP_NLINE-1:0] pinOut,
  output logic [bpp_pkg::BPP_NLINE-1:0] pinOe,
  // Alternate functions
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altOut,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altEnable,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altDirAuto,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altDirOut,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altPwm,
  output logic [bpp_pkg::BPP_NLINE-1:0] altIn,
  // Input threshold per byte, one means raised hysteresis thresholds
  output logic [bpp_pkg::BPP_NBYTE-1:0] threshCmos
);
  import bpp_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Per-port software controls.
  logic [15:0] latch_r [BPP_NPORT];
  logic [15:0] latch_nxt [BPP_NPORT];
  logic [15:0] dir_r [BPP_NPORT];
  logic [15:0] dir_nxt [BPP_NPORT];
  logic [15:0] od_r [BPP_NPORT];
  logic [15:0] od_nxt [BPP_NPORT];
  // Threshold selects, one bit per byte group.
  logic [BPP_THR_W-1:0] thr_r;
  logic [BPP_THR_W-1:0] thr_nxt;
  logic [BPP_XTHR_W-1:0] xthr_r;
  logic [BPP_XTHR_W-1:0] xthr_nxt;
  logic [BPP_NBYTE-1:0] threshCmos_r;
  logic [BPP_NBYTE-1:0] threshCmos_nxt;
  // Bus handshake and its registered answer.
  bpp_state_t state_r;
  bpp_state_t state_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  // Pin samples, one cycle behind the pads.
  logic [15:0] inSample [BPP_NPORT];
  logic [BPP_NLINE-1:0] autoDir;

  // Lines with hardware direction control, including those fixed at reset.
  assign autoDir = altDirAuto | RESET_AUTO_DIR;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Field codes returned by the decoder.
  localparam logic [2:0] F_DATA = 3'h0;
  localparam logic [2:0] F_DIR = 3'h1;
  localparam logic [2:0] F_OD = 3'h2;
  localparam logic [2:0] F_TGL = 3'h3;
  localparam logic [2:0] F_THR = 3'h4;
  localparam logic [2:0] F_XTHR = 3'h5;
  localparam logic [2:0] F_NONE = 3'h7;

  // Turns an address into a field code; the port number only serves the range check.
  // Threshold words lie past the port windows, so they match first.
  function automatic logic [2:0] decodeField(input logic [BPP_AW-1:0] a);
    logic [BPP_AW-1:0] portNum;
    portNum = a >> BPP_PORT_SHIFT;
    if (a == BPP_OFF_THR) begin
      decodeField = F_THR;
    end else if (a == BPP_OFF_XTHR) begin
      decodeField = F_XTHR;
    end else if (portNum >= BPP_AW'(BPP_NPORT)) begin
      decodeField = F_NONE;
    end else begin
      // Gaps inside a port window answer with an error.
      unique case (a[3:0])
        BPP_OFF_DATA: decodeField = F_DATA;
        BPP_OFF_DIR: decodeField = F_DIR;
        BPP_OFF_OD: decodeField = F_OD;
        BPP_OFF_TGL: decodeField = F_TGL;
        default: decodeField = F_NONE;
      endcase
    end
  endfunction

  // Value a read of the data word gives: latch where driven, pin elsewhere.
  // Software direction decides, so a line owned by the bus still reads
  // like a plain port line.
  function automatic logic [15:0] portView(input logic [15:0] lat, input logic [15:0] d,
                                           input logic [15:0] smp);
    portView = (lat & d) | (smp & ~d);
  endfunction

  // ----------------------------------------------------------------------
  // Pin slices
  // ----------------------------------------------------------------------
  // Masks drop absent lines and drivers at elaboration, so no
  // register bit can reach a missing pad.
  for (genvar p = 0; p < BPP_NPORT; p++) begin : gPort
    bpp_port_slice #(
      .IMPL_MASK(bpp_impl_mask(p)),
      .DRV_MASK(bpp_drv_mask(p)),
      .OD_MASK(bpp_od_mask(p))
    ) uSlice (
      .sys_clk(sys_clk),
      .rst(rst),
      .latch(latch_r[p]),
      .pinDir(dir_r[p]),
      .odSel(od_r[p]),
      .altOut(altOut[p*BPP_PW +: BPP_PW]),
      .altEnable(altEnable[p*BPP_PW +: BPP_PW]),
      .altDirAuto(autoDir[p*BPP_PW +: BPP_PW]),
      .altDirOut(altDirOut[p*BPP_PW +: BPP_PW]),
      .altPwm(altPwm[p*BPP_PW +: BPP_PW]),
      .altIn(altIn[p*BPP_PW +: BPP_PW]),
      .pinIn(pinIn[p*BPP_PW +: BPP_PW]),
      .pinOut(pinOut[p*BPP_PW +: BPP_PW]),
      .pinOe(pinOe[p*BPP_PW +: BPP_PW]),
      .inSample(inSample[p])
    );
  end

  // ----------------------------------------------------------------------
  // Bus handshake and register writes
  // ----------------------------------------------------------------------
  // One wait state lets read data and the error flag come from flip-flops.
  // A write lands only on the edge where the master sees pready high.
  // Read data is captured one edge early; a pad that moves in between
  // is not seen by that read.
  always_comb begin
    logic [2:0] fld;
    logic [3:0] pIdx;
    logic [15:0] laneMask;
    logic [15:0] cur;
    fld = decodeField(paddr);
    pIdx = 4'(paddr >> BPP_PORT_SHIFT);
    // Byte lanes let each half of a 16-bit port be written on its own.
    laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    cur = 16'h0000;
    state_nxt = state_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    thr_nxt = thr_r;
    xthr_nxt = xthr_r;
    // Every port register holds unless a write below changes it.
    for (int p = 0; p < BPP_NPORT; p++) begin
      latch_nxt[p] = latch_r[p];
      dir_nxt[p] = dir_r[p];
      od_nxt[p] = od_r[p];
    end
    unique case (state_r)
      BPP_ST_IDLE: begin
        // An access seen in idle is answered at the next edge.
        if (psel && penable) begin
          state_nxt = BPP_ST_RESP;
          pready_nxt = 1'b1;
          pslverr_nxt = (fld == F_NONE);
          prdata_nxt = 32'h0000_0000;
          for (int p = 0; p < BPP_NPORT; p++) begin
            if (pIdx == 4'(p)) begin
              unique case (fld)
                F_DATA, F_TGL: prdata_nxt[15:0] = portView(latch_r[p], dir_r[p], inSample[p]);
                F_DIR: prdata_nxt[15:0] = dir_r[p];
                F_OD: prdata_nxt[15:0] = od_r[p];
                default: prdata_nxt[15:0] = 16'h0000;
              endcase
            end
          end
          if (fld == F_THR) begin
            prdata_nxt[BPP_THR_W-1:0] = thr_r;
          end
          if (fld == F_XTHR) begin
            prdata_nxt[BPP_XTHR_W-1:0] = xthr_r;
          end
        end
      end
      BPP_ST_RESP: begin
        state_nxt = BPP_ST_IDLE;
        if (psel && penable && pwrite && !pslverr_r) begin
          for (int p = 0; p < BPP_NPORT; p++) begin
            if (pIdx == 4'(p)) begin
              cur = portView(latch_r[p], dir_r[p], inSample[p]);
              unique case (fld)
                // A plain write lands in the latch of every line with a driver, driven or not.
                F_DATA: begin
                  latch_nxt[p] = ((pwdata[15:0] & laneMask) | (latch_r[p] & ~laneMask))
                    & bpp_drv_mask(p);
                end
                // Hardware read-modify-write: the read view is inverted where
                // the written bit is one and stored into the latch.
                F_TGL: begin
                  latch_nxt[p] = (((cur ^ pwdata[15:0]) & laneMask) | (latch_r[p] & ~laneMask))
                    & bpp_drv_mask(p);
                end
                // Direction bits of absent or input-only lines stay zero.
                F_DIR: begin
                  dir_nxt[p] = ((pwdata[15:0] & laneMask) | (dir_r[p] & ~laneMask))
                    & bpp_drv_mask(p);
                end
                // Only lines with an open-drain driver keep these bits.
                F_OD: begin
                  od_nxt[p] = ((pwdata[15:0] & laneMask) | (od_r[p] & ~laneMask))
                    & bpp_od_mask(p);
                end
                default: begin
                  cur = 16'h0000;
                end
              endcase
            end
          end
          // Threshold words ignore the byte lanes.
          if (fld == F_THR) begin
            thr_nxt = pwdata[BPP_THR_W-1:0];
          end
          if (fld == F_XTHR) begin
            xthr_nxt = pwdata[BPP_XTHR_W-1:0];
          end
        end
      end
      // An illegal state code falls back to idle.
      default: begin
        state_nxt = BPP_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Threshold fan-out
  // ----------------------------------------------------------------------
  // Each byte takes its select bit; absent upper bytes of byte ports stay low.
  // A new select reaches its byte one cycle after the write lands.
  always_comb begin
    logic [BPP_THR_W+BPP_XTHR_W-1:0] allThr;
    int idx;
    allThr = {xthr_r, thr_r};
    idx = 0;
    threshCmos_nxt = '0;
    for (int p = 0; p < BPP_NPORT; p++) begin
      for (int b = 0; b < 2; b++) begin
        idx = bpp_thr_bit(p, b);
        if (idx >= 0) begin
          threshCmos_nxt[p*2+b] = allThr[idx];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Port controls return to input and push-pull with the latch low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < BPP_NPORT; p++) begin
        latch_r[p] <= BPP_RST_LATCH;
        dir_r[p] <= BPP_RST_DIR;
        od_r[p] <= BPP_RST_OD;
      end
    end else begin
      for (int p = 0; p < BPP_NPORT; p++) begin
        latch_r[p] <= latch_nxt[p];
        dir_r[p] <= dir_nxt[p];
        od_r[p] <= od_nxt[p];
      end
    end
  end

  // Threshold selects return to the standard level.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      thr_r <= BPP_RST_THR;
      xthr_r <= BPP_RST_XTHR;
      threshCmos_r <= '0;
    end else begin
      thr_r <= thr_nxt;
      xthr_r <= xthr_nxt;
      threshCmos_r <= threshCmos_nxt;
    end
  end

  // Bus handshake; an access cut by reset is dropped, and the master
  // must start it again.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= BPP_ST_IDLE;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Bus answers come straight from their flip-flops.
  // Pad outputs already leave the slices registered.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign threshCmos = threshCmos_r;

endmodule

// ---- rtl/bpp_port_slice.sv ----
`timescale 1ns/1ps

module bpp_port_slice #(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter logic [15:0] DRV_MASK = 16'hFFFF,
  parameter logic [15:0] OD_MASK = 16'h0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Software controls
  input wire logic [15:0] latch,
  input wire logic [15:0] pinDir,
  input wire logic [15:0] odSel,
  // Alternate function side
  input wire logic [15:0] altOut,
  input wire logic [15:0] altEnable,
  input wire logic [15:0] altDirAuto,
  input wire logic [15:0] altDirOut,
  input wire logic [15:0] altPwm,
  output logic [15:0] altIn,
  // Pad side
  input wire logic [15:0] pinIn,
  output logic [15:0] pinOut,
  output logic [15:0] pinOe,
  output logic [15:0] inSample
);
  import bpp_pkg::*;

  logic [15:0] pinOut_nxt;
  logic [15:0] pinOe_nxt;
  logic [15:0] inSample_nxt;
  logic [15:0] altIn_nxt;
  logic [15:0] effDir;
  logic [15:0] drive;

  // ----------------------------------------------------------------------
  // Pad and alternate path
  // ----------------------------------------------------------------------
  // The driven level is the latch ANDed with the alternate data, PWM lines
  // bypass the latch so software may leave it at any value.
  always_comb begin
    effDir = ((altDirAuto & altDirOut) | (~altDirAuto & pinDir)) & DRV_MASK;
    drive = latch;
    drive = (altEnable & ~altPwm & (latch & altOut)) | (altEnable & altPwm & altOut)
      | (~altEnable & latch);
    pinOut_nxt = drive & ~(odSel & OD_MASK) & effDir;
    // Open drain only pulls low; a high is left to the external pull-up.
    pinOe_nxt = effDir & ~(odSel & OD_MASK & drive);
    inSample_nxt = pinIn & IMPL_MASK;
    // An output line feeds its own latch back to the alternate input.
    altIn_nxt = ((effDir & latch) | (~effDir & inSample)) & IMPL_MASK;
  end

  // Registers of the pad path.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinOut <= 16'h0000;
      pinOe <= 16'h0000;
      inSample <= 16'h0000;
      altIn <= 16'h0000;
    end else begin
      pinOut <= pinOut_nxt;
      pinOe <= pinOe_nxt;
      inSample <= inSample_nxt;
      altIn <= altIn_nxt;
    end
  end

endmodule

// ---- tb/bidir_port_pin_logic_tb.sv ----
`timescale 1ns/1ps

module bidir_port_pin_logic_tb;
  import bpp_pkg::*;

  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [BPP_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, wd;
  logic [3:0] pstrb;
  logic [BPP_NLINE-1:0] pinIn, pinOut, pinOe, altOut, altEnable, altDirAuto, altDirOut, altPwm, altIn, extLevel;
  logic [BPP_NBYTE-1:0] threshCmos;
  logic [15:0] mLat [9];
  logic [15:0] mDir [9];
  logic [15:0] mOd [9];
  logic [13:0] mThr;
  logic [11:0] a;
  int mismatches, comparisons, seed, p, op;
  logic [15:0] implM [9] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hBFFF, 16'h00FF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF};
  int thrIdx [18] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, -1, 9, 10, 11, -1, 12, -1, 13, -1};

  bpp_port_bank DUT (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .altOut(altOut), .altEnable(altEnable),
    .altDirAuto(altDirAuto), .altDirOut(altDirOut), .altPwm(altPwm), .altIn(altIn), .threshCmos(threshCmos)
  );

  bpp_ext_device uExt (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

  // Free-running system clock.
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [143:0] rnd144();
    logic [159:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    return r[143:0];
  endfunction

  // Pad behaviour of one port from the model's controls and the bench's alternate inputs.
  task automatic padModel(input int q, output logic [15:0] oe, output logic [15:0] out, output logic [15:0] lvl,
                          output logic [15:0] ain);
    logic [15:0] au, ed, dv, en, ao, pw, od, drv;
    au = altDirAuto[q*16+:16];
    en = altEnable[q*16+:16];
    ao = altOut[q*16+:16];
    pw = altPwm[q*16+:16];
    drv = (q == 5) ? 16'h0000 : implM[q];
    od = mOd[q];
    ed = (au & altDirOut[q*16+:16]) | (~au & mDir[q]);
    dv = (en & pw & ao) | (en & ~pw & mLat[q] & ao) | (~en & mLat[q]);
    oe = ((od & ed & ~dv) | (~od & ed)) & drv;
    out = ~od & ed & dv & drv;
    lvl = (oe & out) | (~oe & extLevel[q*16+:16]);
    ain = ((ed & mLat[q]) | (~ed & lvl)) & implM[q];
  endtask

  // Value a read of address x should return.
  task automatic expRead(input logic [11:0] x, output logic [31:0] e);
    logic [15:0] oe, out, lvl, ain;
    int q;
    q = int'(x[7:4]);
    padModel(q, oe, out, lvl, ain);
    case (x[3:0])
      4'h4: e = 32'(mDir[q]);
      4'h8: e = 32'(mOd[q]);
      default: e = 32'(((mDir[q] & mLat[q]) | (~mDir[q] & lvl)) & implM[q]);
    endcase
    if (x == BPP_OFF_THR) e = 32'(mThr[10:0]);
    if (x == BPP_OFF_XTHR) e = 32'(mThr[13:11]);
    if (x[9]) e = 32'h00000000;
  endtask

  task automatic modWrite(input logic [11:0] x, input logic [31:0] d, input logic [3:0] st, input logic [31:0] rv);
    logic [15:0] m, drv;
    int q;
    q = int'(x[7:4]);
    m = {{8{st[1]}}, {8{st[0]}}};
    drv = (q == 5) ? 16'h0000 : implM[q];
    if (x == BPP_OFF_THR) mThr[10:0] = d[10:0];
    else if (x == BPP_OFF_XTHR) mThr[13:11] = d[2:0];
    else if (!x[9]) begin
      case (x[3:0])
        4'h0: mLat[q] = ((mLat[q] & ~m) | (d[15:0] & m)) & drv;
        4'h4: mDir[q] = ((mDir[q] & ~m) | (d[15:0] & m)) & drv;
        4'h8: mOd[q] = ((mOd[q] & ~m) | (d[15:0] & m)) & ((q >= 2 && q != 5) ? implM[q] : 16'h0000);
        default: mLat[q] = ((mLat[q] & ~m) | ((rv[15:0] ^ d[15:0]) & m)) & drv;
      endcase
    end
  endtask

  // One APB transfer; entered just after a rising edge, returns at the edge that sampled pready.
  task automatic apb(input logic wr, input logic [11:0] x, input logic [31:0] d, input logic [3:0] st,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= x;
    pwdata <= d;
    pstrb <= st;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 100);
    if (n >= 100) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic access(input logic wr, input logic [11:0] x, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] e, rd;
    logic er;
    expRead(x, e);
    apb(wr, x, d, st, rd, er);
    chk("pslverr", 32'(x[9]), 32'(er));
    if (wr) modWrite(x, d, st, e);
    else chk("prdata", e, rd);
  endtask

  task automatic padCheck();
    logic [15:0] oe, out, lvl, ain;
    logic [17:0] te;
    for (int q = 0; q < 9; q++) begin
      padModel(q, oe, out, lvl, ain);
      chk("pinOe", 32'(oe), 32'(pinOe[q*16+:16]));
      chk("pinOut", 32'(out), 32'(pinOut[q*16+:16]));
      chk("altIn", 32'(ain), 32'(altIn[q*16+:16] & implM[q]));
    end
    for (int i = 0; i < 18; i++) te[i] = (thrIdx[i] < 0) ? 1'h0 : mThr[thrIdx[i]];
    chk("threshCmos", 32'(te), 32'(threshCmos));
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence: reset values, then random traffic against the model, then a second reset.
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    rst = 1'h1;
    {altOut, altEnable, altDirAuto, altDirOut, altPwm, extLevel} = '0;
    seed = 32'hf405;
    mThr = '0;
    for (int i = 0; i < 9; i++) {mLat[i], mDir[i], mOd[i]} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    for (int q = 0; q < 9; q++) for (int r = 0; r < 3; r++) access(1'h0, 12'(q * 16 + r * 4), 32'h0, 4'h0);
    access(1'h0, BPP_OFF_THR, 32'h0, 4'h0);
    access(1'h0, BPP_OFF_XTHR, 32'h0, 4'h0);
    for (int it = 0; it < 200; it++) begin
      p = {$random(seed)} % 9;
      op = {$random(seed)} % 6;
      wd = $random(seed);
      a = (op < 4) ? 12'(p * 16 + op * 4) : (op == 4) ? (wd[31] ? BPP_OFF_XTHR : BPP_OFF_THR) : 12'h200;
      // Alternate functions change only between accesses, hardware direction on every port but port 5.
      extLevel <= rnd144();
      altOut <= rnd144();
      altEnable <= rnd144();
      altPwm <= rnd144();
      altDirAuto <= rnd144() & rnd144() & ~(144'hFFFF << 80);
      altDirOut <= rnd144();
      repeat (4) @(posedge sys_clk);
      access(1'h1, a, wd, (op >= 3) ? 4'h3 : 4'(wd[17:16]));
      repeat (4) @(posedge sys_clk);
      padCheck();
      access(1'h0, a, 32'h0, 4'h0);
      access(1'h0, 12'(p * 16), 32'h0, 4'h0);
    end
    {altOut, altEnable, altDirAuto, altDirOut, altPwm} <= '0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    mThr = '0;
    for (int i = 0; i < 9; i++) {mLat[i], mDir[i], mOd[i]} = '0;
    // Pad samples reach the alternate inputs two edges after release.
    repeat (3) @(posedge sys_clk);
    padCheck();
    complete_run();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule

// ---- tb/bpp_ext_device.sv ----
`timescale 1ns/1ps

module bpp_ext_device
  import bpp_pkg::*;
(
  // Design pads
  input wire logic [bpp_pkg::BPP_NLINE-1:0] pinOut,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] pinOe,
  // Level the outside circuit forces on lines nobody drives
  input wire logic [bpp_pkg::BPP_NLINE-1:0] extLevel,
  // Level seen by the pad inputs
  output logic [bpp_pkg::BPP_NLINE-1:0] pinIn
);
  // A released line shows the outside level, never a stale driven value.
  always_comb begin
    pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
  end
endmodule

// ---- tb/bpp_port_monitor.sv ----
`timescale 1ns/1ps

module bpp_port_monitor
  import bpp_pkg::*;
#(
  parameter logic [143:0] RESET_AUTO_DIR = 144'h0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bpp_pkg::BPP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pads and alternate functions
  input wire logic [bpp_pkg::BPP_NLINE-1:0] pinIn,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] pinOut,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] pinOe,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altOut,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altEnable,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altDirAuto,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altDirOut,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altPwm,
  input wire logic [bpp_pkg::BPP_NLINE-1:0] altIn,
  input wire logic [bpp_pkg::BPP_NBYTE-1:0] threshCmos
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // First cycle of an access phase.
  sequence accessStart;
    psel && penable && !$past(penable);
  endsequence

  // Line 1 of port 0 under hardware direction, driving a PWM signal.
  sequence pwmLine;
    altDirAuto[1] && altDirOut[1] && altEnable[1] && altPwm[1];
  endsequence

  a_ready_one_wait: assert property (accessStart |=> pready) else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_ready_needs_access: assert property (pready |-> $past(psel) && $past(penable)) else $error("stray pready");
  a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_input_only_port: assert property (pinOe[95:80] == 16'h0000) else $error("port 5 driven");
  a_absent_lines: assert property (!pinOe[62] && !pinOut[62] && pinOe[79:72] == 8'h00 &&
    pinOe[111:104] == 8'h00 && pinOe[127:120] == 8'h00 && pinOe[143:136] == 8'h00) else $error("absent line driven");
  a_released_zero: assert property ((pinOut & ~pinOe) == '0) else $error("value on released pad");
  a_reset_input_dir: assert property ($fell(rst) |-> pinOe == '0) else $error("driver on after reset");
  a_auto_dir_follow: assert property ((altDirAuto[0] | RESET_AUTO_DIR[0]) |=> pinOe[0] == $past(altDirOut[0]))
    else $error("auto direction not followed");
  a_pwm_bypass: assert property (pwmLine |=> pinOut[1] == $past(altOut[1])) else $error("pwm output gated");
endmodule

bind bpp_port_bank bpp_port_monitor #(.RESET_AUTO_DIR(RESET_AUTO_DIR)) uMonitor (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .altOut(altOut), .altEnable(altEnable),
  .altDirAuto(altDirAuto), .altDirOut(altDirOut), .altPwm(altPwm), .altIn(altIn), .threshCmos(threshCmos)
);
